// ==== osc_pkg.sv ====
// Package with register map, field layout and state types of the oscillator control block.
package osc_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_KEY  = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_CLR  = 8'h0c;
  localparam logic [7:0] OFF_EN   = 8'h10;

  // Unlock keys, values are arbitrary.
  localparam logic [31:0] KEY_FIRST  = 32'haa996655;
  localparam logic [31:0] KEY_SECOND = 32'h556699aa;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int MULT_LO    = 16;
  localparam int CUR_LO     = 12;
  localparam int REQ_LO     = 8;
  localparam int LOCK_B     = 7;
  localparam int USB_LOCK_B = 6;
  localparam int SYS_LOCK_B = 5;
  localparam int SLP_B      = 4;
  localparam int FAIL_B     = 3;

  // Interrupt status bits.
  localparam int IRQ_W       = 4;
  localparam int IRQ_FAIL    = 0;
  localparam int IRQ_SWITCH  = 1;
  localparam int IRQ_SYSLOCK = 2;
  localparam int IRQ_BADKEY  = 3;

  // Cycle after reset release at which the synchronised configuration is valid.
  localparam logic [1:0] CFG_LOAD = 2'h2;
  localparam logic [1:0] CFG_DONE = 2'h3;

  typedef enum logic [1:0] {
    ULK_IDLE = 2'b00,
    ULK_HALF = 2'b01,
    ULK_OPEN = 2'b10
  } osc_ulk_e;

  typedef struct packed {
    logic       fail;
    logic       sys_lock;
    logic       usb_lock;
    logic       ack;
    logic [2:0] cfg_src;
    logic [1:0] cfg_swmon;
  } osc_sync_s;

  typedef struct packed {
    osc_sync_s          sync1;
    osc_sync_s          sync2;
    logic [1:0]         init_cnt;
    logic [2:0]         mult;
    logic [4:0]         factor;
    logic [2:0]         cur;
    logic [2:0]         req;
    logic               lock;
    logic               slp;
    logic               fail_flag;
    osc_ulk_e           ulk;
    logic               sw_req;
    logic               sys_lock_d;
    logic [IRQ_W-1:0]   irq_st;
    logic [IRQ_W-1:0]   irq_en;
    logic               irq;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
    logic               sleep_req;
    logic               idle_req;
  } osc_state_s;

endpackage

// ==== osc_ctrl.sv ====
// Oscillator control register block with unlock guard, clock switch handshake and APB slave.
//
// Functional notes
// - Multiplier field selects factor 15..21, 24.
// - Current source field reports active clock.
// - Requested source field names switch target.
// - Reset loads requested source from configuration.
// - Lock bit freezes selections when switching disabled.
// - Switching enabled means selections never locked.
// - USB PLL lock bit mirrors lock status.
// - System PLL lock bit mirrors lock status.
// - Wait enters Sleep or Idle per bit.
// - Clock fail flag set on monitor failure.
// - Control writes need prior unlock sequence.
// - Bits 15 and 11 read zero.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps

module osc_ctrl (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Configuration word fields
  input  wire logic [2:0]  initial_source_config,
  input  wire logic [1:0]  switch_monitor_config,
  // Oscillator and monitor status, asynchronous
  input  wire logic        clk_fail_detect,
  input  wire logic        sys_pll_lock_raw,
  input  wire logic        usb_pll_lock_raw,
  input  wire logic        switch_done,
  // Core
  input  wire logic        wait_exec,
  // Clock system controls
  output logic      [2:0]  pll_multiplier_select,
  output logic      [4:0]  pll_mult_factor,
  output logic      [2:0]  requested_source_select,
  output logic      [2:0]  current_source_select,
  output logic             switch_request,
  output logic             sleep_req,
  output logic             idle_req,
  output logic             irq
);

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == osc_pkg::OFF_CTRL) || (a == osc_pkg::OFF_KEY) || (a == osc_pkg::OFF_STAT) ||
               (a == osc_pkg::OFF_CLR) || (a == osc_pkg::OFF_EN);
  endfunction

  function automatic logic [4:0] mult_factor(input logic [2:0] m);
    case (m)
      3'h0: mult_factor = 5'h0f;
      3'h1: mult_factor = 5'h10;
      3'h2: mult_factor = 5'h11;
      3'h3: mult_factor = 5'h12;
      3'h4: mult_factor = 5'h13;
      3'h5: mult_factor = 5'h14;
      3'h6: mult_factor = 5'h15;
      default: mult_factor = 5'h18;
    endcase
  endfunction

  osc_pkg::osc_state_s s;
  osc_pkg::osc_state_s n;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic                     frozen;
    logic                     acc;
    logic                     wr_ctrl;
    logic                     wr_key;
    logic [osc_pkg::IRQ_W-1:0] ev;
    logic [osc_pkg::IRQ_W-1:0] clr;
    logic [31:0]              rd;
    frozen  = 1'b0;
    acc     = psel & penable & s.pready;
    wr_ctrl = acc & pwrite & (paddr == osc_pkg::OFF_CTRL);
    wr_key  = acc & pwrite & (paddr == osc_pkg::OFF_KEY);
    ev      = '0;
    clr     = '0;
    rd      = 32'h00000000;
    n       = s;

    // Second stage alone reads the first.
    // Status pins are asynchronous; a first-stage value may still be settling.
    n.sync1 = {clk_fail_detect, sys_pll_lock_raw, usb_pll_lock_raw, switch_done,
               initial_source_config, switch_monitor_config};
    n.sync2 = s.sync1;

    if (s.init_cnt != osc_pkg::CFG_DONE) begin
      n.init_cnt = s.init_cnt + 2'h1;
      if (s.init_cnt == osc_pkg::CFG_LOAD) begin
        n.req = s.sync2.cfg_src;
        n.cur = s.sync2.cfg_src;
      end
    end

    frozen = s.sync2.cfg_swmon[1] & s.lock;

    if (wr_key) begin
      case (s.ulk)
        osc_pkg::ULK_IDLE: n.ulk = (pwdata == osc_pkg::KEY_FIRST) ? osc_pkg::ULK_HALF : osc_pkg::ULK_IDLE;
        osc_pkg::ULK_HALF: begin
          n.ulk = (pwdata == osc_pkg::KEY_SECOND) ? osc_pkg::ULK_OPEN : osc_pkg::ULK_IDLE;
          ev[osc_pkg::IRQ_BADKEY] = (pwdata != osc_pkg::KEY_SECOND);
        end
        osc_pkg::ULK_OPEN: n.ulk = osc_pkg::ULK_OPEN;
        default: n.ulk = osc_pkg::ULK_IDLE;
      endcase
    end

    // accept control write only when open
    if (wr_ctrl) begin
      if (s.ulk == osc_pkg::ULK_OPEN) begin
        // One write closes the guard again, so a stray store later cannot land.
        n.ulk = osc_pkg::ULK_IDLE;
        n.slp = pwdata[osc_pkg::SLP_B];
        if (!pwdata[osc_pkg::FAIL_B]) begin
          n.fail_flag = 1'b0;
        end
        if (!frozen) begin
          n.mult = pwdata[osc_pkg::MULT_LO +: 3];
          n.req  = pwdata[osc_pkg::REQ_LO +: 3];
          n.lock = pwdata[osc_pkg::LOCK_B];
        end
      end else begin
        ev[osc_pkg::IRQ_BADKEY] = 1'b1;
      end
    end

    // fail flag, a new failure beats a clear
    if (s.sync2.fail) begin
      n.fail_flag = 1'b1;
      ev[osc_pkg::IRQ_FAIL] = 1'b1;
    end

    n.factor = mult_factor(n.mult);

    if (s.sw_req && s.sync2.ack) begin
      n.cur    = s.req;
      n.sw_req = 1'b0;
      ev[osc_pkg::IRQ_SWITCH] = 1'b1;
    end else if (!s.sw_req && !s.sync2.ack && s.init_cnt == osc_pkg::CFG_DONE && s.req != s.cur) begin
      n.sw_req = 1'b1;
    end

    n.sys_lock_d = s.sync2.sys_lock;
    ev[osc_pkg::IRQ_SYSLOCK] = s.sync2.sys_lock & ~s.sys_lock_d;

    n.sleep_req = wait_exec & s.slp;
    n.idle_req  = wait_exec & ~s.slp;

    // Register writes of the interrupt group.
    if (acc && pwrite && paddr == osc_pkg::OFF_CLR) begin
      clr = pwdata[osc_pkg::IRQ_W-1:0];
    end
    if (acc && pwrite && paddr == osc_pkg::OFF_EN) begin
      n.irq_en = pwdata[osc_pkg::IRQ_W-1:0];
    end
    // Set wins over a simultaneous clear.
    n.irq_st = (s.irq_st & ~clr) | ev;
    n.irq    = |(n.irq_st & n.irq_en);

    case (paddr)
      osc_pkg::OFF_CTRL: begin
        rd[osc_pkg::MULT_LO +: 3] = s.mult;
        rd[osc_pkg::CUR_LO +: 3]  = s.cur;
        rd[osc_pkg::REQ_LO +: 3]  = s.req;
        rd[osc_pkg::LOCK_B]       = s.lock;
        rd[osc_pkg::USB_LOCK_B]   = s.sync2.usb_lock;
        rd[osc_pkg::SYS_LOCK_B]   = s.sync2.sys_lock;
        rd[osc_pkg::SLP_B]        = s.slp;
        rd[osc_pkg::FAIL_B]       = s.fail_flag;
      end
      osc_pkg::OFF_STAT: rd[osc_pkg::IRQ_W-1:0] = s.irq_st;
      osc_pkg::OFF_EN:   rd[osc_pkg::IRQ_W-1:0] = s.irq_en;
      default:           rd = 32'h00000000;
    endcase

    // Answer one cycle after setup, no wait states.
    n.pready  = psel & ~penable;
    n.pslverr = psel & ~penable & ~addr_hit(paddr);
    if (psel && !penable) begin
      n.prdata = rd;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      // Field zero selects factor 15, so the decoded output starts there too.
      s.factor <= 5'h0f;
    end else begin
      s <= n;
    end
  end

  assign prdata                  = s.prdata;
  assign pready                  = s.pready;
  assign pslverr                 = s.pslverr;
  assign pll_multiplier_select   = s.mult;
  assign pll_mult_factor         = s.factor;
  assign requested_source_select = s.req;
  assign current_source_select   = s.cur;
  assign switch_request          = s.sw_req;
  assign sleep_req               = s.sleep_req;
  assign idle_req                = s.idle_req;
  assign irq                     = s.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  mult_factor_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.mult == 3'h7) |-> (s.factor == 5'h18)) else $error("Multiplier 7 does not give 24.");

  cur_switch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.init_cnt == osc_pkg::CFG_DONE && $past(s.init_cnt) == osc_pkg::CFG_DONE && $changed(s.cur))
    |-> ($past(s.sw_req) && $past(s.sync2.ack)))
    else $error("Current source changed without a finished switch.");

  cfg_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.init_cnt == osc_pkg::CFG_LOAD) |=> (s.req == $past(s.sync2.cfg_src)))
    else $error("Requested source not loaded from configuration.");

  lock_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && s.pready && pwrite && paddr == osc_pkg::OFF_CTRL && s.lock && s.sync2.cfg_swmon[1])
    |=> $stable(s.req) && $stable(s.mult)) else $error("Locked selection was modified.");

  never_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && s.pready && pwrite && paddr == osc_pkg::OFF_CTRL && s.ulk == osc_pkg::ULK_OPEN
     && !s.sync2.cfg_swmon[1] && s.init_cnt == osc_pkg::CFG_DONE)
    |=> (s.req == $past(pwdata[10:8]))) else $error("Selection locked while switching enabled.");

  unlock_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && s.pready && pwrite && paddr == osc_pkg::OFF_CTRL && s.ulk != osc_pkg::ULK_OPEN)
    |=> $stable(s.slp) && $stable(s.lock)) else $error("Control write taken without unlock.");

  sleep_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
    wait_exec |=> (sleep_req == $past(s.slp)) && (idle_req == !$past(s.slp)))
    else $error("Wait mode choice wrong.");

  fail_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    s.sync2.fail |=> s.fail_flag && s.irq_st[osc_pkg::IRQ_FAIL]) else $error("Clock failure not flagged.");

  zero_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.pready && paddr == osc_pkg::OFF_CTRL) |-> (prdata[15] == 1'b0 && prdata[11] == 1'b0 && prdata[31:19] == 13'h0))
    else $error("Unimplemented bits read non-zero.");

  sys_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == osc_pkg::OFF_CTRL) |=> (prdata[osc_pkg::SYS_LOCK_B] == $past(s.sync2.sys_lock)))
    else $error("System PLL lock readback wrong.");

  usb_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == osc_pkg::OFF_CTRL) |=> (prdata[osc_pkg::USB_LOCK_B] == $past(s.sync2.usb_lock)))
    else $error("USB PLL lock readback wrong.");

  cur_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && paddr == osc_pkg::OFF_CTRL) |=> (prdata[osc_pkg::CUR_LO +: 3] == $past(s.cur)))
    else $error("Current source readback wrong.");

  key_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && s.pready && pwrite && paddr == osc_pkg::OFF_KEY && s.ulk == osc_pkg::ULK_HALF
     && pwdata == osc_pkg::KEY_SECOND) |=> (s.ulk == osc_pkg::ULK_OPEN))
    else $error("Correct key pair did not open the guard.");

  // The request must stand until the switcher answers, or the source could change twice.
  switch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.sw_req && !s.sync2.ack) |=> s.sw_req)
    else $error("Switch request dropped before its answer.");

  switch_target_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s.sw_req && s.sync2.ack) |=> (s.cur == $past(s.req)))
    else $error("Switch did not land on the requested source.");

endmodule // osc_ctrl

// ==== tb_osc_ctrl.sv ====
// Self-checking testbench for the oscillator control block.
`timescale 1ns/1ps

module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  initial_source_config;
  logic [1:0]  switch_monitor_config;
  logic        clk_fail_detect;
  logic        sys_pll_lock_raw;
  logic        usb_pll_lock_raw;
  logic        switch_done;
  logic        wait_exec;
  logic [2:0]  pll_multiplier_select;
  logic [4:0]  pll_mult_factor;
  logic [2:0]  requested_source_select;
  logic [2:0]  current_source_select;
  logic        switch_request;
  logic        sleep_req;
  logic        idle_req;
  logic        irq;
  int          err_total;
  int          num_checks;
  int          cycles;
  logic [31:0] rd;
  logic        er;
  logic [4:0]  fac [8] = '{5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h18};

  osc_ctrl osc_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .initial_source_config(initial_source_config), .switch_monitor_config(switch_monitor_config),
    .clk_fail_detect(clk_fail_detect), .sys_pll_lock_raw(sys_pll_lock_raw),
    .usb_pll_lock_raw(usb_pll_lock_raw), .switch_done(switch_done), .wait_exec(wait_exec),
    .pll_multiplier_select(pll_multiplier_select), .pll_mult_factor(pll_mult_factor),
    .requested_source_select(requested_source_select), .current_source_select(current_source_select),
    .switch_request(switch_request), .sleep_req(sleep_req), .idle_req(idle_req), .irq(irq)
  );

  // ---------------------------------------------------------------
  // Clock, timeout and report
  // ---------------------------------------------------------------
  always #2 pclk = ~pclk;

  // The run needs a few hundred cycles; the ceiling leaves ample margin.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      err_total = err_total + 1;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // APB master tasks
  // ---------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctrl_wr(input logic [31:0] d);
    xfer(1'b1, osc_pkg::OFF_KEY, osc_pkg::KEY_FIRST);
    xfer(1'b1, osc_pkg::OFF_KEY, osc_pkg::KEY_SECOND);
    xfer(1'b1, osc_pkg::OFF_CTRL, d);
  endtask

  function automatic logic [31:0] cv(input logic [2:0] m, input logic [2:0] r, input logic l, input logic s);
    return (32'(m) << osc_pkg::MULT_LO) | (32'(r) << osc_pkg::REQ_LO) |
           (32'(l) << osc_pkg::LOCK_B) | (32'(s) << osc_pkg::SLP_B);
  endfunction

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; initial_source_config = 3'h5; switch_monitor_config = 2'h0;
    clk_fail_detect = 1'b0; sys_pll_lock_raw = 1'b0; usb_pll_lock_raw = 1'b0;
    switch_done = 1'b0; wait_exec = 1'b0; err_total = 0; num_checks = 0; cycles = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    xfer(1'b0, osc_pkg::OFF_CTRL, 32'h0);
    chk(32'(rd[10:8]), 32'h5, "req after reset");
    chk(32'(rd[14:12]), 32'h5, "cur after reset");
    chk(32'({rd[15], rd[11]}), 32'h0, "unused bits");
    chk(32'(pll_mult_factor), 32'h0f, "factor after reset");
    xfer(1'b0, 8'h14, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped err");
    chk(rd, 32'h0, "unmapped data");
    // Write without unlock, then with a wrong second key.
    xfer(1'b1, osc_pkg::OFF_CTRL, cv(3'h6, 3'h5, 1'b0, 1'b1));
    xfer(1'b1, osc_pkg::OFF_KEY, osc_pkg::KEY_FIRST);
    xfer(1'b1, osc_pkg::OFF_KEY, 32'h12345678);
    xfer(1'b1, osc_pkg::OFF_CTRL, cv(3'h6, 3'h5, 1'b0, 1'b1));
    xfer(1'b0, osc_pkg::OFF_CTRL, 32'h0);
    chk(32'({rd[18:16], rd[4]}), 32'h0, "guarded write");
    xfer(1'b0, osc_pkg::OFF_STAT, 32'h0);
    chk(32'(rd[osc_pkg::IRQ_BADKEY]), 32'h1, "badkey status");
    for (int i = 0; i < 8; i++) begin
      // Ones in the unused positions must be dropped.
      ctrl_wr(cv(3'(i), 3'h5, 1'b0, 1'b1) | 32'h00008800);
      xfer(1'b0, osc_pkg::OFF_CTRL, 32'h0);
      chk(32'(rd[18:16]), 32'(i), "mult field");
      chk(32'({rd[15], rd[11]}), 32'h0, "unused after write");
      chk(32'(pll_mult_factor), 32'(fac[i]), "mult factor");
      chk(32'(pll_multiplier_select), 32'(i), "mult port");
    end
    for (int s = 1; s >= 0; s--) begin
      ctrl_wr(cv(3'h7, 3'h5, 1'b0, 1'(s)));
      @(posedge pclk);
      wait_exec <= 1'b1;
      @(posedge pclk);
      wait_exec <= 1'b0;
      @(posedge pclk);
      chk(32'({sleep_req, idle_req}), (s == 1) ? 32'h2 : 32'h1, "wait mode");
    end
    for (int p = 0; p < 4; p++) begin
      usb_pll_lock_raw <= p[0];
      sys_pll_lock_raw <= p[1];
      repeat (4) @(posedge pclk);
      xfer(1'b0, osc_pkg::OFF_CTRL, 32'h0);
      chk(32'(rd[6]), 32'(p[0]), "usb lock");
      chk(32'(rd[5]), 32'(p[1]), "sys lock");
    end
    // Bad key status is set but masked; only the failure event is enabled.
    xfer(1'b1, osc_pkg::OFF_EN, 32'h1);
    xfer(1'b0, osc_pkg::OFF_EN, 32'h0);
    chk(rd, 32'h1, "enable readback");
    chk({31'h0, irq}, 32'h0, "irq masked");
    clk_fail_detect <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({31'h0, irq}, 32'h1, "irq on fail");
    xfer(1'b0, osc_pkg::OFF_CTRL, 32'h0);
    chk(32'(rd[3]), 32'h1, "fail flag");
    clk_fail_detect <= 1'b0;
    repeat (4) @(posedge pclk);
    ctrl_wr(cv(3'h7, 3'h5, 1'b0, 1'b0));
    xfer(1'b1, osc_pkg::OFF_CLR, 32'hf);
    xfer(1'b0, osc_pkg::OFF_CTRL, 32'h0);
    chk(32'(rd[3]), 32'h0, "fail cleared");
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // Source switch handshake.
    ctrl_wr(cv(3'h7, 3'h2, 1'b0, 1'b0));
    for (int n = 0; n < 20 && switch_request !== 1'b1; n++) @(posedge pclk);
    chk(32'({switch_request, requested_source_select}), 32'ha, "switch request");
    chk(32'(current_source_select), 32'h5, "cur before done");
    switch_done <= 1'b1;
    for (int n = 0; n < 20 && current_source_select !== 3'h2; n++) @(posedge pclk);
    @(posedge pclk);
    chk(32'({switch_request, current_source_select}), 32'h2, "cur after done");
    switch_done <= 1'b0;
    xfer(1'b0, osc_pkg::OFF_STAT, 32'h0);
    chk(32'(rd[osc_pkg::IRQ_SWITCH]), 32'h1, "switch status");
    // Lock bit has no effect while switching is enabled, then freezes.
    ctrl_wr(cv(3'h3, 3'h2, 1'b1, 1'b0));
    ctrl_wr(cv(3'h4, 3'h2, 1'b1, 1'b0));
    xfer(1'b0, osc_pkg::OFF_CTRL, 32'h0);
    chk(32'({rd[7], rd[18:16]}), 32'hc, "unlocked sel");
    switch_monitor_config <= 2'h2;
    repeat (4) @(posedge pclk);
    ctrl_wr(cv(3'h6, 3'h3, 1'b0, 1'b0));
    xfer(1'b0, osc_pkg::OFF_CTRL, 32'h0);
    chk(32'({rd[18:16], rd[10:8]}), 32'h22, "frozen sel");
    chk(32'(pll_multiplier_select), 32'h4, "frozen port");
    final_report();
  end
endmodule  // tb_top
